// >>> eia_accept.v
// Function
// - Instruction-fetch and operand access exceptions rank below interrupt requests.
// - Among interrupts the controller picks by level, then lowest source index.
// - Interrupt and trap vectors come from the interrupt table base.
// - System exception vectors come from the exception table base.
// - Privileged at 0x50, access at 0x54, undefined at 0x5C in exception table.
// - Floating-point at 0x64, non-maskable at 0x78 in exception table.
// - Reset vector is fixed at 0xFFFFFFFC, never relocated.
// - Fast interrupt takes its handler from the fast handler address register.
// - 4-bit mask; accept only when source level is strictly above it.
// - Global enable bit in status word; 0 blocks, 1 permits maskable interrupts.
// - Global enable is 1 after reset.
// - Accepting any event clears the global enable to 0.
// - A request sets its source status flag to 1.
// - Sixteen pins, each low level, falling, rising or both-edge detection.
// - Each pin has a configurable digital noise filter before detection.
// - Peripheral sources use edge or level detection and may be grouped.
// - Edge-detected source flag clears automatically on acceptance.
// - Level-detected ungrouped peripheral source clears peripheral flag and status flag on acceptance.
`timescale 1ns/1ps
`default_nettype none
`include "eia_map.vh"
module eia_accept (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt sources
  input wire [15:0] external_pin_request,
  input wire [7:0] periph_req,
  output reg [7:0] periph_clr,
  // Exception requests from the core
  input wire nmi_req,
  input wire exc_fetch_acc,
  input wire exc_undef,
  input wire exc_priv,
  input wire trap_req,
  input wire [7:0] trap_num,
  input wire exc_oper_acc,
  input wire exc_fpu,
  // Event presented to the core
  output reg evt_valid,
  output reg [3:0] evt_kind,
  output reg [31:0] evt_addr,
  input wire evt_ack,
  // Status word view and interrupt
  output reg [3:0] cpu_priority_mask,
  output reg cpu_int_enable,
  output reg irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] interrupt_table_base_q, exception_table_base_q, fast_handler_address_q, pmode_q, hist_q;
  reg [15:0] filt_en_q, pin_s1_q, pin_s2_q, filt_q, filt_prev_q;
  reg [7:0] per_lvl_q, per_grp_q, per_prev_q;
  reg [4:0] fast_src_q, src_q;
  reg [3:0] mask_q, estat_q, emask_q;
  reg [1:0] filt_div_q;
  reg ie_q, fast_en_q;
  reg [99:0] lvl_q;
  reg [`EIA_NSRC-1:0] istat_q;
  reg [5:0] div_cnt_q;

  function [3:0] lvl_of;
    input [99:0] lv;
    input [4:0] idx;
    begin
      lvl_of = lv[idx*4 +: 4];
    end
  endfunction

  // ----------------------------------------
  // Source detection: filter divider, pins and peripherals
  // ----------------------------------------
  reg [5:0] div_lim;
  wire tick;
  always @* begin
    case (filt_div_q)
      2'h0: div_lim = `EIA_DIV1;
      2'h1: div_lim = `EIA_DIV8;
      2'h2: div_lim = `EIA_DIV32;
      default: div_lim = `EIA_DIV64;
    endcase
  end
  assign tick = (div_cnt_q >= div_lim);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 6'h00;
    end else if (tick) begin
      div_cnt_q <= 6'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end
  wire [15:0] pin_set;
  genvar g;
  generate
    for (g = 0; g < `EIA_NPIN; g = g + 1) begin : pin
      wire [1:0] md;
      assign md = pmode_q[2*g +: 2];
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hist_q[2*g +: 2] <= 2'h3;
          filt_q[g] <= 1'b1;
        end else if (!filt_en_q[g]) begin
          hist_q[2*g +: 2] <= {pin_s2_q[g], pin_s2_q[g]};
          filt_q[g] <= pin_s2_q[g];
        end else if (tick) begin
          // Three equal samples in a row move the filtered level
          hist_q[2*g +: 2] <= {hist_q[2*g], pin_s2_q[g]};
          if (hist_q[2*g+1] == pin_s2_q[g] && hist_q[2*g] == pin_s2_q[g]) begin
            filt_q[g] <= pin_s2_q[g];
          end
        end
      end
      assign pin_set[g] = (md == `EIA_DET_LOW) ? ~filt_q[g] :
                          (md == `EIA_DET_FALL) ? (filt_prev_q[g] & ~filt_q[g]) :
                          (md == `EIA_DET_RISE) ? (~filt_prev_q[g] & filt_q[g]) :
                          (filt_prev_q[g] ^ filt_q[g]);
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 16'hFFFF;
      pin_s2_q <= 16'hFFFF;
      filt_prev_q <= 16'hFFFF;
      per_prev_q <= 8'h00;
    end else begin
      pin_s1_q <= external_pin_request;
      pin_s2_q <= pin_s1_q;
      filt_prev_q <= filt_q;
      per_prev_q <= periph_req;
    end
  end
  wire [7:0] per_det;
  wire [7:0] per_set;
  wire grp_set;
  assign per_det = (per_lvl_q & periph_req) | (~per_lvl_q & periph_req & ~per_prev_q);
  assign per_set = per_det & ~per_grp_q;
  assign grp_set = |(per_det & per_grp_q);

  // ----------------------------------------
  // Interrupt arbitration and event selection
  // ----------------------------------------
  reg int_ok;
  reg [4:0] win;
  reg [3:0] win_lvl;
  integer i;
  always @* begin
    int_ok = 1'b0;
    win = 5'h00;
    win_lvl = 4'h0;
    for (i = 0; i < `EIA_NSRC; i = i + 1) begin
      // Strictly above the mask; ties go to the lowest index
      if (istat_q[i] && lvl_of(lvl_q, i[4:0]) > mask_q && (!int_ok || lvl_of(lvl_q, i[4:0]) > win_lvl)) begin
        int_ok = 1'b1;
        win = i[4:0];
        win_lvl = lvl_of(lvl_q, i[4:0]);
      end
    end
  end

  reg [7:0] win_vec;
  always @* begin
    if (win < 5'd16) begin
      win_vec = `EIA_VEC_PIN + {3'h0, win};
    end else if (win < 5'd24) begin
      win_vec = `EIA_VEC_PER + {3'h0, win - 5'd16};
    end else begin
      win_vec = `EIA_VEC_GRP;
    end
  end
  reg sel_v;
  reg [3:0] sel_k;
  reg [31:0] sel_a;
  always @* begin
    sel_v = 1'b1;
    sel_k = `EIA_K_NMI;
    sel_a = exception_table_base_q + `EIA_XOFF_NMI;
    if (nmi_req) begin
      sel_k = `EIA_K_NMI;
    end else if (int_ok && ie_q) begin
      if (fast_en_q && win == fast_src_q) begin
        sel_k = `EIA_K_FAST;
        sel_a = fast_handler_address_q;
      end else begin
        sel_k = `EIA_K_INT;
        sel_a = interrupt_table_base_q + {22'h0, win_vec, 2'h0};
      end
    end else if (exc_fetch_acc) begin
      sel_k = `EIA_K_FACC;
      sel_a = exception_table_base_q + `EIA_XOFF_ACC;
    end else if (exc_undef) begin
      sel_k = `EIA_K_UND;
      sel_a = exception_table_base_q + `EIA_XOFF_UND;
    end else if (exc_priv) begin
      sel_k = `EIA_K_PRIV;
      sel_a = exception_table_base_q + `EIA_XOFF_PRIV;
    end else if (trap_req) begin
      sel_k = `EIA_K_TRAP;
      sel_a = interrupt_table_base_q + {22'h0, trap_num, 2'h0};
    end else if (exc_oper_acc) begin
      sel_k = `EIA_K_OACC;
      sel_a = exception_table_base_q + `EIA_XOFF_ACC;
    end else if (exc_fpu) begin
      sel_k = `EIA_K_FPU;
      sel_a = exception_table_base_q + `EIA_XOFF_FPU;
    end else begin
      sel_v = 1'b0;
    end
  end

  // ----------------------------------------
  // Presentation to the core
  // ----------------------------------------
  wire take;
  wire take_int;
  wire [7:0] per_take;
  assign take = evt_valid & evt_ack;
  assign take_int = take & (evt_kind == `EIA_K_INT || evt_kind == `EIA_K_FAST);
  assign per_take = (take_int && src_q >= 5'd16 && src_q < 5'd24) ? (per_lvl_q & (8'h01 << (src_q - 5'd16))) : 8'h00;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_valid <= 1'b1;
      evt_kind <= `EIA_K_RESET;
      evt_addr <= `EIA_RESET_VEC;
      src_q <= 5'h00;
      periph_clr <= 8'h00;
    end else begin
      periph_clr <= per_take;
      if (take) begin
        evt_valid <= 1'b0;
      end else if (!evt_valid && sel_v) begin
        evt_valid <= 1'b1;
        evt_kind <= sel_k;
        evt_addr <= sel_a;
        src_q <= win;
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire wr;
  wire setup;
  reg hit;
  reg [31:0] rd;
  assign wr = psel & penable & pwrite & pready;
  assign setup = psel & ~penable;

  always @* begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (paddr)
      `EIA_OFF_ITB: rd = interrupt_table_base_q;
      `EIA_OFF_ETB: rd = exception_table_base_q;
      `EIA_OFF_FHA: rd = fast_handler_address_q;
      `EIA_OFF_PSW: rd = {15'h0, ie_q, 12'h0, mask_q};
      `EIA_OFF_PMODE: rd = pmode_q;
      `EIA_OFF_FILT: rd = {14'h0, filt_div_q, filt_en_q};
      `EIA_OFF_PCFG: rd = {16'h0, per_grp_q, per_lvl_q};
      `EIA_OFF_FSRC: rd = {23'h0, fast_en_q, 3'h0, fast_src_q};
      `EIA_OFF_LVL0: rd = lvl_q[31:0];
      `EIA_OFF_LVL1: rd = lvl_q[63:32];
      `EIA_OFF_LVL2: rd = lvl_q[95:64];
      `EIA_OFF_LVL3: rd = {28'h0, lvl_q[99:96]};
      `EIA_OFF_ISTAT: rd = {7'h0, istat_q};
      `EIA_OFF_ESTAT: rd = {28'h0, estat_q};
      `EIA_OFF_EMASK: rd = {28'h0, emask_q};
      default: hit = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd : 32'h0000_0000;
      pslverr <= setup & ~hit;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_table_base_q <= 32'h0000_0000;
      exception_table_base_q <= 32'h0000_0000;
      fast_handler_address_q <= 32'h0000_0000;
      pmode_q <= 32'h0000_0000;
      filt_en_q <= 16'h0000;
      filt_div_q <= 2'h0;
      per_lvl_q <= 8'h00;
      per_grp_q <= 8'h00;
      fast_src_q <= 5'h00;
      fast_en_q <= 1'b0;
      lvl_q <= 100'h0;
      emask_q <= 4'h0;
    end else if (wr) begin
      case (paddr)
        `EIA_OFF_ITB: interrupt_table_base_q <= pwdata;
        `EIA_OFF_ETB: exception_table_base_q <= pwdata;
        `EIA_OFF_FHA: fast_handler_address_q <= pwdata;
        `EIA_OFF_PMODE: pmode_q <= pwdata;
        `EIA_OFF_FILT: begin
          filt_en_q <= pwdata[15:0];
          filt_div_q <= pwdata[`EIA_FILT_DIV_LSB +: 2];
        end
        `EIA_OFF_PCFG: begin
          per_lvl_q <= pwdata[7:0];
          per_grp_q <= pwdata[15:8];
        end
        `EIA_OFF_FSRC: begin
          fast_src_q <= pwdata[4:0];
          fast_en_q <= pwdata[`EIA_FSRC_EN_BIT];
        end
        `EIA_OFF_LVL0: lvl_q[31:0] <= pwdata;
        `EIA_OFF_LVL1: lvl_q[63:32] <= pwdata;
        `EIA_OFF_LVL2: lvl_q[95:64] <= pwdata;
        `EIA_OFF_LVL3: lvl_q[99:96] <= pwdata[3:0];
        `EIA_OFF_EMASK: emask_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `EIA_PSW_MASK_RST;
      ie_q <= `EIA_PSW_IE_RST;
    end else begin
      if (wr && paddr == `EIA_OFF_PSW) begin
        mask_q <= pwdata[`EIA_PSW_MASK_MSB:0];
        ie_q <= pwdata[`EIA_PSW_IE_BIT];
      end
      if (take) begin
        ie_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status flags and interrupt output
  // ----------------------------------------
  wire [`EIA_NSRC-1:0] src_set;
  wire [`EIA_NSRC-1:0] src_clr;
  assign src_set = {grp_set, per_set & ~(per_take | periph_clr), pin_set};
  assign src_clr = (take_int ? ({{(`EIA_NSRC-1){1'b0}}, 1'b1} << src_q) : {`EIA_NSRC{1'b0}}) |
                   ((wr && paddr == `EIA_OFF_ISTAT) ? pwdata[`EIA_NSRC-1:0] : {`EIA_NSRC{1'b0}});

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_q <= {`EIA_NSRC{1'b0}};
    end else begin
      // A new request wins over the clear in the same cycle
      istat_q <= (istat_q & ~src_clr) | src_set;
    end
  end
  wire [3:0] ev;
  assign ev[0] = take_int;
  assign ev[1] = take & ~take_int & (evt_kind != `EIA_K_NMI);
  assign ev[2] = take & (evt_kind == `EIA_K_NMI);
  assign ev[3] = int_ok & ~ie_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      estat_q <= 4'h0;
      irq <= 1'b0;
      cpu_priority_mask <= 4'h0;
      cpu_int_enable <= 1'b0;
    end else begin
      estat_q <= (estat_q & ~((wr && paddr == `EIA_OFF_ESTAT) ? pwdata[3:0] : 4'h0)) | ev;
      irq <= |(estat_q & emask_q);
      cpu_priority_mask <= mask_q;
      cpu_int_enable <= ie_q;
    end
  end

endmodule
`default_nettype wire

// >>> eia_map.vh
`ifndef EIA_MAP_VH
`define EIA_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EIA_OFF_ITB 8'h00
`define EIA_OFF_ETB 8'h04
`define EIA_OFF_FHA 8'h08
`define EIA_OFF_PSW 8'h0C
`define EIA_OFF_PMODE 8'h10
`define EIA_OFF_FILT 8'h14
`define EIA_OFF_PCFG 8'h18
`define EIA_OFF_FSRC 8'h1C
`define EIA_OFF_LVL0 8'h20
`define EIA_OFF_LVL1 8'h24
`define EIA_OFF_LVL2 8'h28
`define EIA_OFF_LVL3 8'h2C
`define EIA_OFF_ISTAT 8'h30
`define EIA_OFF_ESTAT 8'h34
`define EIA_OFF_EMASK 8'h38
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EIA_PSW_MASK_MSB 3
`define EIA_PSW_IE_BIT 16
`define EIA_PSW_RST 32'h0001_0000
`define EIA_PSW_MASK_RST 4'h0
`define EIA_PSW_IE_RST 1'b1
`define EIA_FILT_DIV_LSB 16
`define EIA_FSRC_EN_BIT 8
// ----------------------------------------
// Source layout
// ----------------------------------------
`define EIA_NPIN 16
`define EIA_NPER 8
`define EIA_NSRC 25
`define EIA_SRC_GRP 24
`define EIA_VEC_PIN 8'h40
`define EIA_VEC_PER 8'h50
`define EIA_VEC_GRP 8'h58
// ----------------------------------------
// Fixed addresses and exception offsets
// ----------------------------------------
`define EIA_RESET_VEC 32'hFFFF_FFFC
`define EIA_XOFF_PRIV 32'h0000_0050
`define EIA_XOFF_ACC 32'h0000_0054
`define EIA_XOFF_UND 32'h0000_005C
`define EIA_XOFF_FPU 32'h0000_0064
`define EIA_XOFF_NMI 32'h0000_0078
// ----------------------------------------
// Event kinds
// ----------------------------------------
`define EIA_K_RESET 4'h0
`define EIA_K_NMI 4'h1
`define EIA_K_INT 4'h2
`define EIA_K_FAST 4'h3
`define EIA_K_FACC 4'h4
`define EIA_K_UND 4'h5
`define EIA_K_PRIV 4'h6
`define EIA_K_TRAP 4'h7
`define EIA_K_OACC 4'h8
`define EIA_K_FPU 4'h9
// ----------------------------------------
// Pin detection modes and filter timing
// ----------------------------------------
`define EIA_DET_LOW 2'h0
`define EIA_DET_FALL 2'h1
`define EIA_DET_RISE 2'h2
`define EIA_DET_BOTH 2'h3
`define EIA_DIV1 6'h00
`define EIA_DIV8 6'h07
`define EIA_DIV32 6'h1F
`define EIA_DIV64 6'h3F
`endif

// >>> eia_accept_chk.sv
`timescale 1ns/1ps
`default_nettype none
module eia_accept_chk (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Core requests
  input wire logic nmi_req,
  input wire logic exc_fetch_acc,
  // Event side
  input wire logic [7:0] periph_clr,
  input wire logic evt_valid,
  input wire logic [3:0] evt_kind,
  input wire logic [31:0] evt_addr,
  input wire logic evt_ack,
  input wire logic cpu_int_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    evt_valid && evt_ack;
  endsequence
  sequence s_new;
    $rose(evt_valid);
  endsequence
  a_reset_fixed: assert property (evt_valid && evt_kind == 4'h0 |-> evt_addr == 32'hFFFF_FFFC)
    else $error("reset event address moved");
  a_take_drops: assert property (s_take |=> !evt_valid)
    else $error("event still shown after take");
  a_take_ie_off: assert property (s_take |-> ##2 !cpu_int_enable)
    else $error("enable not cleared by take");
  a_evt_holds: assert property (evt_valid && !evt_ack |=> evt_valid && $stable(evt_kind) && $stable(evt_addr))
    else $error("event changed before take");
  a_ie_blocks: assert property (!cpu_int_enable [*3] ##1 (!cpu_int_enable and s_new) |-> evt_kind != 4'h2)
    else $error("interrupt taken while disabled");
  a_nmi_first: assert property (s_new and $past(nmi_req) |-> evt_kind == 4'h1)
    else $error("non-maskable event outranked");
  a_fetch_rank: assert property (s_new and $past(exc_fetch_acc) && !$past(nmi_req) |-> evt_kind inside {4'h2, 4'h3, 4'h4})
    else $error("fetch access exception misranked");
  a_clr_cause: assert property (|periph_clr |-> $past(evt_valid && evt_ack && evt_kind inside {4'h2, 4'h3}))
    else $error("peripheral clear without take");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// >>> eia_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module eia_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core side
  input wire logic evt_valid,
  input wire logic [3:0] ack_dly,
  output logic evt_ack,
  // Peripheral side
  input wire logic [7:0] periph_set,
  input wire logic [7:0] periph_clr,
  output logic [7:0] periph_req
);
  logic [3:0] wait_q;
  // Core takes each event after a chosen delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      evt_ack <= 1'b0;
    end else if (evt_valid && evt_ack) begin
      wait_q <= 4'h0;
      evt_ack <= 1'b0;
    end else if (evt_valid) begin
      if (wait_q >= ack_dly)
        evt_ack <= 1'b1;
      else
        wait_q <= wait_q + 4'h1;
    end
  end
  // Peripheral flag holds until the controller clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      periph_req <= 8'h00;
    else
      periph_req <= (periph_req & ~periph_clr) | periph_set;
  end
endmodule
`default_nettype wire

// >>> eia_accept_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "eia_map.vh"
module eia_accept_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, evt_valid, evt_ack, cpu_int_enable, irq, e;
  logic [7:0] paddr, trap_num, periph_req, periph_clr, periph_set;
  logic [31:0] pwdata, prdata, evt_addr, q;
  logic [15:0] pins;
  logic [6:0] creq;
  logic [3:0] evt_kind, cpu_priority_mask, ack_dly;
  logic [3:0] ek [7] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [31:0] ea [7] = '{32'h2078, 32'h2054, 32'h205C, 32'h2050, 32'h1084, 32'h2054, 32'h2064};
  int n_fail, n_checks, i;
  eia_accept i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_pin_request(pins), .periph_req(periph_req), .periph_clr(periph_clr),
    .nmi_req(creq[0]), .exc_fetch_acc(creq[1]), .exc_undef(creq[2]), .exc_priv(creq[3]),
    .trap_req(creq[4]), .trap_num(trap_num), .exc_oper_acc(creq[5]), .exc_fpu(creq[6]),
    .evt_valid(evt_valid), .evt_kind(evt_kind), .evt_addr(evt_addr), .evt_ack(evt_ack),
    .cpu_priority_mask(cpu_priority_mask), .cpu_int_enable(cpu_int_enable), .irq(irq));
  eia_far_model i_far (.clk(clk), .rst_n(rst_n), .evt_valid(evt_valid), .ack_dly(ack_dly),
    .evt_ack(evt_ack), .periph_set(periph_set), .periph_clr(periph_clr), .periph_req(periph_req));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(k < 50, 1'b1, "bus answer");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp, "read data");
  endtask
  task automatic expect_evt(input logic [3:0] k, input logic [31:0] a, input logic [6:0] drop);
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (!(evt_valid === 1'b1 && evt_ack === 1'b1) && t < 300);
    chk(t < 300, 1'b1, "event timeout");
    chk(evt_kind, k, "event kind");
    chk(evt_addr, a, "vector address");
    @(posedge clk);
    creq <= creq & ~drop;
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | evt_valid;
    end
    chk(seen, 1'b0, "unexpected event");
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    periph_set <= v;
    @(posedge clk);
    periph_set <= 8'h00;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, creq, periph_set} = '0;
    pins = 16'hFFFF;
    trap_num = 8'h21;
    ack_dly = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(evt_addr, 32'hFFFF_FFFC, "reset vector");
    rd(`EIA_OFF_PSW, `EIA_PSW_RST);
    apb(1'b0, 8'hFC, 32'h0);
    chk(e, 1'b1, "unmapped error");
    expect_evt(4'h0, 32'hFFFF_FFFC, 7'h00);
    ack_dly <= 4'h3;
    apb(1'b1, `EIA_OFF_ITB, 32'h1000);
    apb(1'b1, `EIA_OFF_ETB, 32'h2000);
    apb(1'b1, `EIA_OFF_FHA, 32'h3300);
    creq <= 7'h7F;
    for (i = 0; i < 7; i++)
      expect_evt(ek[i], ea[i], 7'h01 << i);
    apb(1'b1, `EIA_OFF_LVL0 + 8'h08, 32'h5);
    apb(1'b1, `EIA_OFF_PCFG, 32'h1);
    pulse(8'h01);
    quiet(20);
    rd(`EIA_OFF_ISTAT, 32'h0001_0000);
    apb(1'b1, `EIA_OFF_PSW, 32'h0001_0005);
    quiet(20);
    apb(1'b1, `EIA_OFF_PSW, 32'h0001_0004);
    creq <= 7'h02;
    expect_evt(4'h2, 32'h1140, 7'h00);
    expect_evt(4'h4, 32'h2054, 7'h02);
    chk(periph_req, 8'h00, "level flag cleared");
    rd(`EIA_OFF_ISTAT, 32'h0);
    rd(`EIA_OFF_PSW, 32'h4);
    rd(`EIA_OFF_ESTAT, 32'hF);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, `EIA_OFF_EMASK, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, `EIA_OFF_ESTAT, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0, "irq cleared");
    rd(`EIA_OFF_ESTAT, 32'hE);
    apb(1'b1, `EIA_OFF_ISTAT, 32'hFFFF_FFFF);
    apb(1'b1, `EIA_OFF_PMODE, 32'h40);
    apb(1'b1, `EIA_OFF_LVL0, 32'h7000);
    apb(1'b1, `EIA_OFF_FILT, 32'h0001_0008);
    apb(1'b1, `EIA_OFF_PSW, 32'h0001_0000);
    pins[3] <= 1'b0;
    expect_evt(4'h2, 32'h110C, 7'h00);
    apb(1'b1, `EIA_OFF_PSW, 32'h0001_0000);
    quiet(30);
    ack_dly <= 4'h0;
    apb(1'b1, `EIA_OFF_LVL0 + 8'h08, 32'hF);
    apb(1'b1, `EIA_OFF_FSRC, 32'h110);
    pulse(8'h01);
    expect_evt(4'h3, 32'h3300, 7'h00);
    apb(1'b1, `EIA_OFF_FSRC, 32'h0);
    apb(1'b1, `EIA_OFF_PCFG, 32'h200);
    apb(1'b1, `EIA_OFF_LVL3, 32'h6);
    apb(1'b1, `EIA_OFF_ISTAT, 32'hFFFF_FFFF);
    apb(1'b1, `EIA_OFF_PSW, 32'h0001_0000);
    pulse(8'h02);
    expect_evt(4'h2, 32'h1160, 7'h00);
    end_of_test();
  end
endmodule
bind eia_accept eia_accept_chk i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .nmi_req(nmi_req), .exc_fetch_acc(exc_fetch_acc), .periph_clr(periph_clr),
  .evt_valid(evt_valid), .evt_kind(evt_kind), .evt_addr(evt_addr), .evt_ack(evt_ack),
  .cpu_int_enable(cpu_int_enable));
`default_nettype wire
